// ---- eag_pkg.sv ----
// shared constants, modes and carriers of the effective address datapath
package eag_pkg;

  // ------------------------------------------------------------------
  // instruction word field positions
  // ------------------------------------------------------------------
  localparam int OPC_HI  = 15;  // mode-selecting opcode nibble
  localparam int OPC_LO  = 12;
  localparam int RN_HI   = 11;  // operand register number
  localparam int RN_LO   = 8;
  localparam int RM_HI   = 7;   // source register number
  localparam int RM_LO   = 4;
  localparam int D4_HI   = 3;   // short displacement
  localparam int D4_LO   = 0;
  localparam int IMM_HI  = 7;   // byte immediate or long displacement
  localparam int IMM_LO  = 0;
  localparam int SZR_HI  = 1;   // size field, register modes
  localparam int SZR_LO  = 0;
  localparam int SZD_HI  = 9;   // size field, displacement modes
  localparam int SZD_LO  = 8;

  // ------------------------------------------------------------------
  // opcode nibble codes
  // ------------------------------------------------------------------
  localparam logic [3:0] OPC_DIRECT  = 4'h0;
  localparam logic [3:0] OPC_INDIR   = 4'h1;
  localparam logic [3:0] OPC_POSTINC = 4'h2;
  localparam logic [3:0] OPC_PREDEC  = 4'h3;
  localparam logic [3:0] OPC_DISP4   = 4'h4;
  localparam logic [3:0] OPC_INDEXED = 4'h5;
  localparam logic [3:0] OPC_GBRDISP = 4'h6;
  localparam logic [3:0] OPC_GBRIDX  = 4'h7;
  localparam logic [3:0] OPC_PCREG   = 4'h8;
  localparam logic [3:0] OPC_IMMZERO = 4'h9;
  localparam logic [3:0] OPC_IMMSIGN = 4'ha;
  localparam logic [3:0] OPC_TRAP    = 4'hb;

  // access size codes; their scaling shifts of 0, 1 and 2 come from size_shift
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;

  // values after reset
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [3:0]  REG_RESET  = 4'h0;

  typedef enum logic [3:0] {
    MODE_NONE, MODE_DIRECT, MODE_INDIR, MODE_POSTINC, MODE_PREDEC,
    MODE_DISP4, MODE_INDEXED, MODE_GBRDISP, MODE_GBRIDX, MODE_PCREG,
    MODE_IMMZERO, MODE_IMMSIGN, MODE_TRAP
  } mode_e;

  // register file values read for the request
  typedef struct packed {
    logic [31:0] field_n;      // register named by bits 11:8
    logic [31:0] field_m;      // register named by bits 7:4
    logic [31:0] index_zero;   // index register zero
    logic [31:0] global_base;  // global base register
    logic [31:0] pc;           // program counter
  } reg_view_s;

  // answer to the memory access stage
  typedef struct packed {
    mode_e       mode;
    logic        mem_access;
    logic [31:0] address;
    logic        operand_valid;
    logic [31:0] operand;
    logic        target_valid;
    logic [31:0] target;
    logic        illegal;
  } result_s;

  // pointer register write-back
  typedef struct packed {
    logic        valid;
    logic [3:0]  reg_num;
    logic [31:0] value;
  } writeback_s;

endpackage

// ---- effective_address_gen.sv ----
// effective address, immediate extension and pointer write-back datapath
//
// Overview of operation
// RULE1: direct mode: no memory address, operand is register contents.
// RULE2: indirect mode: address is operand register unchanged.
// RULE3: post-increment: access at old value, write back after completion.
// RULE4: post-increment adds one, two or four by access size.
// RULE5: pre-decrement: subtract first, write back, use result as address.
// RULE6: pre-decrement subtracts one, two or four by access size.
// RULE7: short displacement zero-extended, scaled by size, added to register.
// RULE8: indexed mode: operand register plus index register zero.
// RULE9: long displacement zero-extended, added to global base register.
// RULE10: long displacement scaled by size before the addition.
// RULE11: indexed global mode: global base plus index zero, unscaled.
// RULE12: register-relative mode: program counter plus operand register.
// RULE13: reduced build option removes register-relative mode.
// RULE14: logic and bit-test immediates are zero-extended to 32 bits.
// RULE15: transfer, add and compare immediates are sign-extended.
// RULE16: software exception immediate zero-extended and times four.
// RULE17: instruction word split into four-bit fields.
// RULE18: addressing mode chosen by opcode bits alone.
// RULE19: all address arithmetic is 32-bit modulo, no carry or overflow.
`timescale 1ns/1ps

module effective_address_gen #(
  parameter bit REDUCED_CORE = 1'b0   // drop register-relative mode
) (
  input  wire logic               clock,          // core clock, 50 MHz
  input  wire logic               reset_n,        // sync reset, active low
  input  wire logic               req_valid,      // decoder offers a word
  output logic                    req_ready,      // low while write pends
  input  wire logic [15:0]        instr,          // instruction word
  input  wire eag_pkg::reg_view_s regs,           // register file values
  input  wire logic               instr_complete, // instruction retired
  output logic                    out_valid,      // result pulse
  output eag_pkg::result_s        result,         // to memory stage
  output eag_pkg::writeback_s     wb              // pointer write-back
);

  // ------------------------------------------------------------------
  // field extraction
  // ------------------------------------------------------------------
  logic [3:0]  opc;
  logic [3:0]  rn_num;
  logic [3:0]  d4;
  logic [7:0]  imm8;
  logic [1:0]  size_reg;
  logic [1:0]  size_disp;
  logic        accept;

  // fixed nibble positions, no separate mode field exists
  assign opc       = instr[eag_pkg::OPC_HI:eag_pkg::OPC_LO];    // RULE17
  assign rn_num    = instr[eag_pkg::RN_HI:eag_pkg::RN_LO];      // RULE17
  assign d4        = instr[eag_pkg::D4_HI:eag_pkg::D4_LO];      // RULE17
  assign imm8      = instr[eag_pkg::IMM_HI:eag_pkg::IMM_LO];    // RULE17
  assign size_reg  = instr[eag_pkg::SZR_HI:eag_pkg::SZR_LO];
  assign size_disp = instr[eag_pkg::SZD_HI:eag_pkg::SZD_LO];
  assign accept    = req_valid && req_ready;

  // ------------------------------------------------------------------
  // size scaling
  // ------------------------------------------------------------------
  function automatic logic [1:0] size_shift(input logic [1:0] sz);
    case (sz)
      eag_pkg::SIZE_BYTE: size_shift = 2'd0;
      eag_pkg::SIZE_WORD: size_shift = 2'd1;
      default:            size_shift = 2'd2;
    endcase
  endfunction

  logic [1:0]  shift_reg;
  logic [1:0]  shift_disp;
  logic [31:0] step;
  logic        bad_size_reg;
  logic        bad_size_disp;

  // size code 3 is reserved and flagged rather than guessed
  assign shift_reg     = size_shift(size_reg);
  assign shift_disp    = size_shift(size_disp);
  assign step          = 32'h0000_0001 << shift_reg;            // RULE4 RULE6
  assign bad_size_reg  = (size_reg == 2'h3);
  assign bad_size_disp = (size_disp == 2'h3);

  // ------------------------------------------------------------------
  // mode decode from the opcode nibble
  // ------------------------------------------------------------------
  eag_pkg::mode_e mode;

  always_comb begin
    case (opc)                                                  // RULE18
      eag_pkg::OPC_DIRECT:  mode = eag_pkg::MODE_DIRECT;
      eag_pkg::OPC_INDIR:   mode = eag_pkg::MODE_INDIR;
      eag_pkg::OPC_POSTINC: mode = eag_pkg::MODE_POSTINC;
      eag_pkg::OPC_PREDEC:  mode = eag_pkg::MODE_PREDEC;
      eag_pkg::OPC_DISP4:   mode = eag_pkg::MODE_DISP4;
      eag_pkg::OPC_INDEXED: mode = eag_pkg::MODE_INDEXED;
      eag_pkg::OPC_GBRDISP: mode = eag_pkg::MODE_GBRDISP;
      eag_pkg::OPC_GBRIDX:  mode = eag_pkg::MODE_GBRIDX;
      eag_pkg::OPC_PCREG:   mode = eag_pkg::MODE_PCREG;
      eag_pkg::OPC_IMMZERO: mode = eag_pkg::MODE_IMMZERO;
      eag_pkg::OPC_IMMSIGN: mode = eag_pkg::MODE_IMMSIGN;
      eag_pkg::OPC_TRAP:    mode = eag_pkg::MODE_TRAP;
      default:              mode = eag_pkg::MODE_NONE;
    endcase
  end

  // ------------------------------------------------------------------
  // address and operand arithmetic, all of it wraps at 32 bits
  // ------------------------------------------------------------------
  eag_pkg::result_s next_result;
  logic [31:0]      next_pend_value;
  logic             next_pend;
  logic             next_wb_now;
  logic [31:0]      decremented;

  assign decremented = regs.field_n - step;                     // RULE6 RULE19

  always_comb begin
    next_result               = '0;
    next_result.mode          = mode;
    next_pend                 = 1'b0;
    next_pend_value           = regs.field_n + step;            // RULE4 RULE19
    next_wb_now               = 1'b0;
    case (mode)
      eag_pkg::MODE_DIRECT: begin
        next_result.operand_valid = 1'b1;                       // RULE1
        next_result.operand       = regs.field_n;               // RULE1
      end
      eag_pkg::MODE_INDIR: begin
        next_result.mem_access = 1'b1;
        next_result.address    = regs.field_n;                  // RULE2
      end
      eag_pkg::MODE_POSTINC: begin
        // old value goes out now, the sum waits for retirement
        next_result.mem_access = !bad_size_reg;
        next_result.address    = regs.field_n;                  // RULE3
        next_result.illegal    = bad_size_reg;
        next_pend              = !bad_size_reg;                 // RULE3
      end
      eag_pkg::MODE_PREDEC: begin
        next_result.mem_access = !bad_size_reg;
        next_result.address    = decremented;                   // RULE5
        next_result.illegal    = bad_size_reg;
        next_wb_now            = !bad_size_reg;                 // RULE5
      end
      eag_pkg::MODE_DISP4: begin
        next_result.mem_access = !bad_size_disp;
        next_result.address    = regs.field_m +
                                 ({28'h000_0000, d4} << shift_disp); // RULE7
        next_result.illegal    = bad_size_disp;
      end
      eag_pkg::MODE_INDEXED: begin
        next_result.mem_access = 1'b1;
        next_result.address    = regs.field_n + regs.index_zero; // RULE8
      end
      eag_pkg::MODE_GBRDISP: begin
        next_result.mem_access = !bad_size_disp;
        next_result.address    = regs.global_base +         // RULE9
                                 ({24'h00_0000, imm8} << shift_disp); // RULE10
        next_result.illegal    = bad_size_disp;
      end
      eag_pkg::MODE_GBRIDX: begin
        next_result.mem_access = 1'b1;
        next_result.address    = regs.global_base + regs.index_zero; // RULE11
      end
      eag_pkg::MODE_PCREG: begin
        // reduced build answers illegal instead of a target
        next_result.target_valid = !REDUCED_CORE;               // RULE13
        next_result.target       = REDUCED_CORE ? eag_pkg::WORD_RESET
                                   : regs.pc + regs.field_n;    // RULE12
        next_result.illegal      = REDUCED_CORE;                // RULE13
      end
      eag_pkg::MODE_IMMZERO: begin
        next_result.operand_valid = 1'b1;
        next_result.operand       = {24'h00_0000, imm8};        // RULE14
      end
      eag_pkg::MODE_IMMSIGN: begin
        next_result.operand_valid = 1'b1;
        next_result.operand       = {{24{imm8[7]}}, imm8};      // RULE15
      end
      eag_pkg::MODE_TRAP: begin
        next_result.operand_valid = 1'b1;
        next_result.operand       = {22'h00_0000, imm8, 2'b00}; // RULE16
      end
      default: begin
        next_result.illegal = 1'b1;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // result register towards the memory stage
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      out_valid <= 1'b0;
      result    <= '0;
    end else begin
      out_valid <= accept;
      if (accept) begin
        result <= next_result;
      end
    end
  end

  // ------------------------------------------------------------------
  // deferred post-increment write-back
  // ------------------------------------------------------------------
  logic        pend;
  logic [3:0]  pend_reg;
  logic [31:0] pend_value;

  // new requests wait while a pointer update is owed, so a later
  // instruction never reads the stale pointer
  assign req_ready = !pend;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pend       <= 1'b0;
      pend_reg   <= eag_pkg::REG_RESET;
      pend_value <= eag_pkg::WORD_RESET;
    end else if (accept && next_pend) begin
      pend       <= 1'b1;                                       // RULE3
      pend_reg   <= rn_num;
      pend_value <= next_pend_value;                            // RULE4
    end else if (pend && instr_complete) begin
      pend       <= 1'b0;                                       // RULE3
    end
  end

  // one write-back port, pre-decrement writes at once
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wb <= '0;
    end else if (accept && next_wb_now) begin
      wb.valid   <= 1'b1;                                       // RULE5
      wb.reg_num <= rn_num;
      wb.value   <= decremented;                                // RULE5
    end else if (pend && instr_complete) begin
      wb.valid   <= 1'b1;                                       // RULE3
      wb.reg_num <= pend_reg;
      wb.value   <= pend_value;
    end else begin
      wb.valid   <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  direct_operand_a: assert property ( // RULE1
    @(posedge clock) disable iff (!reset_n)
    out_valid && result.mode == eag_pkg::MODE_DIRECT |->
      !result.mem_access && result.operand_valid &&
      result.operand == $past(regs.field_n))
    else $error("direct mode operand wrong");

  indirect_address_a: assert property ( // RULE2
    @(posedge clock) disable iff (!reset_n)
    out_valid && result.mode == eag_pkg::MODE_INDIR |->
      result.mem_access && result.address == $past(regs.field_n))
    else $error("indirect address wrong");

  postinc_defer_a: assert property ( // RULE3
    @(posedge clock) disable iff (!reset_n)
    accept && mode == eag_pkg::MODE_POSTINC && !bad_size_reg |=>
      !wb.valid && pend && result.address == $past(regs.field_n))
    else $error("post-increment written too early");

  postinc_write_a: assert property ( // RULE3
    @(posedge clock) disable iff (!reset_n)
    pend && instr_complete |=>
      wb.valid && wb.value == $past(pend_value) && !pend)
    else $error("post-increment write-back missing");

  postinc_step_a: assert property ( // RULE4
    @(posedge clock) disable iff (!reset_n)
    accept && mode == eag_pkg::MODE_POSTINC && size_reg == eag_pkg::SIZE_WORD
      |=> pend_value == $past(regs.field_n) + 32'h0000_0002)
    else $error("post-increment step wrong");

  predec_match_a: assert property ( // RULE5
    @(posedge clock) disable iff (!reset_n)
    out_valid && result.mode == eag_pkg::MODE_PREDEC && !result.illegal |->
      wb.valid && wb.value == result.address)
    else $error("pre-decrement write-back differs");

  predec_step_a: assert property ( // RULE6
    @(posedge clock) disable iff (!reset_n)
    accept && mode == eag_pkg::MODE_PREDEC && size_reg == eag_pkg::SIZE_LONG
      |=> result.address == $past(regs.field_n) - 32'h0000_0004)
    else $error("pre-decrement step wrong");

  disp_short_a: assert property ( // RULE7
    @(posedge clock) disable iff (!reset_n)
    accept && mode == eag_pkg::MODE_DISP4 && size_disp == eag_pkg::SIZE_WORD
      |=> result.address == $past(regs.field_m) +
          {27'h000_0000, $past(d4), 1'b0})
    else $error("short displacement address wrong");

  indexed_sum_a: assert property ( // RULE8
    @(posedge clock) disable iff (!reset_n)
    out_valid && result.mode == eag_pkg::MODE_INDEXED |->
      result.address == $past(regs.field_n) + $past(regs.index_zero))
    else $error("indexed address wrong");

  gbr_disp_a: assert property ( // RULE9 RULE10
    @(posedge clock) disable iff (!reset_n)
    accept && mode == eag_pkg::MODE_GBRDISP && size_disp == eag_pkg::SIZE_LONG
      |=> result.address ==
          $past(regs.global_base) + {22'h00_0000, $past(imm8), 2'b00})
    else $error("global displacement address wrong");

  gbr_index_a: assert property ( // RULE11
    @(posedge clock) disable iff (!reset_n)
    out_valid && result.mode == eag_pkg::MODE_GBRIDX |->
      result.address == $past(regs.global_base) + $past(regs.index_zero))
    else $error("indexed global address wrong");

  pc_target_a: assert property ( // RULE12 RULE13
    @(posedge clock) disable iff (!reset_n)
    out_valid && result.mode == eag_pkg::MODE_PCREG |->
      (REDUCED_CORE ? (!result.target_valid && result.illegal)
       : (result.target_valid &&
          result.target == $past(regs.pc) + $past(regs.field_n))))
    else $error("register-relative target wrong");

  imm_extend_a: assert property ( // RULE14 RULE15 RULE16
    @(posedge clock) disable iff (!reset_n)
    out_valid |->
      (result.mode != eag_pkg::MODE_IMMZERO ||
         result.operand == {24'h00_0000, $past(imm8)}) &&
      (result.mode != eag_pkg::MODE_IMMSIGN ||
         result.operand == {{24{$past(imm8[7])}}, $past(imm8)}) &&
      (result.mode != eag_pkg::MODE_TRAP ||
         result.operand == {22'h00_0000, $past(imm8), 2'b00}))
    else $error("immediate extension wrong");

  mode_decode_a: assert property ( // RULE17 RULE18
    @(posedge clock) disable iff (!reset_n)
    accept && opc == eag_pkg::OPC_GBRIDX |=>
      out_valid && result.mode == eag_pkg::MODE_GBRIDX)
    else $error("mode not taken from opcode");

endmodule

// ---- load_store_stage.sv ----
// behavioural load/store stage that retires post-increment accesses
`timescale 1ns/1ps

module load_store_stage (
  input  wire logic             clock,          // core clock
  input  wire logic             reset_n,        // sync reset, active low
  input  wire logic             out_valid,      // result pulse from block
  input  wire eag_pkg::result_s result,         // result from block
  input  wire logic [3:0]       lag,            // extra cycles to retire
  output logic                  instr_complete  // retire pulse
);
  logic [3:0] count;
  logic       busy;

  // ----------------------------------------------------------------
  // retire timing
  // ----------------------------------------------------------------
  // a slow memory stage holds the pointer update back by lag cycles
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      busy           <= 1'b0;
      count          <= 4'h0;
      instr_complete <= 1'b0;
    end else begin
      instr_complete <= 1'b0;
      if (out_valid && result.mode == eag_pkg::MODE_POSTINC) begin
        busy  <= 1'b1;
        count <= lag;
      end else if (busy && count == 4'h0) begin
        busy           <= 1'b0;
        instr_complete <= 1'b1;
      end else if (busy) begin
        count <= count - 4'h1;
      end
    end
  end
endmodule

// ---- effective_address_gen_tb.sv ----
// self-checking bench of the effective address datapath
`timescale 1ns/1ps

module effective_address_gen_tb;
  logic                clock;
  logic                reset_n;
  logic                req_valid;
  logic                req_ready;
  logic [15:0]         instr;
  eag_pkg::reg_view_s  regs;
  eag_pkg::reg_view_s  rv;
  logic                instr_complete;
  logic                out_valid;
  eag_pkg::result_s    result;
  eag_pkg::result_s    result_r;
  eag_pkg::writeback_s wb;
  logic [3:0]          lag;
  int                  mismatches = 0;
  int                  num_checks = 0;
  int                  cycles = 0;

  effective_address_gen DUT (
    .clock(clock), .reset_n(reset_n), .req_valid(req_valid),
    .req_ready(req_ready), .instr(instr), .regs(regs),
    .instr_complete(instr_complete), .out_valid(out_valid),
    .result(result), .wb(wb));

  // second copy built without the register-relative mode
  effective_address_gen #(.REDUCED_CORE(1'b1)) reduced_dut (
    .clock(clock), .reset_n(reset_n), .req_valid(req_valid),
    .req_ready(), .instr(instr), .regs(regs),
    .instr_complete(instr_complete), .out_valid(),
    .result(result_r), .wb());

  load_store_stage partner (
    .clock(clock), .reset_n(reset_n), .out_valid(out_valid),
    .result(result), .lag(lag), .instr_complete(instr_complete));

  // ----------------------------------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // a hang shows up as a blocked request; cut it short
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // offer one word, hold it until taken, look at the answer cycle
  task automatic send(input logic [15:0] w);
    logic rdy;
    rdy = 1'b0;
    @(posedge clock);
    req_valid <= 1'b1;
    instr     <= w;
    regs      <= rv;
    while (!rdy) begin
      @(negedge clock);
      rdy = req_ready;
      @(posedge clock);
    end
    req_valid <= 1'b0;
    @(negedge clock);
    check(out_valid, 1);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_addr();
    send(16'h0500);
    check(result.operand_valid, 1);
    check(result.operand, rv.field_n);
    check(result.mem_access, 0);
    for (int s = 0; s < 3; s++) begin
      send({4'h1, 4'h5, 6'h00, 2'(s)});
      check(32'(result.mode), 32'(eag_pkg::MODE_INDIR));
      check(result.address, rv.field_n);
      send({4'h4, 2'h0, 2'(s), 4'h0, 4'hf});
      check(result.address, rv.field_m + (32'hf << s));
      send({4'h6, 2'h0, 2'(s), 8'hff});
      check(result.address, rv.global_base + (32'hff << s));
    end
    send(16'h5500);
    check(result.address, rv.field_n + rv.index_zero);
    send(16'h7000);
    check(result.address, rv.global_base + rv.index_zero);
    send(16'h8500);
    check(result.target, rv.pc + rv.field_n);
    check(result.target_valid, 1);
    check(result_r.target_valid, 0);
    check(result_r.illegal, 1);
    check(result_r.target, 32'h0000_0000);
  endtask

  task automatic t_imm();
    logic [7:0] imm;
    for (int i = 0; i < 2; i++) begin
      imm = (i == 0) ? 8'h9c : 8'h7c;
      send({4'h9, 4'h0, imm});
      check(result.operand, {24'h00_0000, imm});
      send({4'ha, 4'h0, imm});
      check(result.operand, {{24{imm[7]}}, imm});
      send({4'hb, 4'h0, imm});
      check(result.operand, {22'h00_0000, imm, 2'h0});
    end
  endtask

  // prompt, then slower retirement of the post-increment access
  task automatic t_postinc();
    int n;
    for (int s = 0; s < 3; s++) begin
      lag = 4'(s * 4);
      send({4'h2, 4'h5, 6'h00, 2'(s)});
      check(result.address, rv.field_n);
      check(req_ready, 0);
      check(wb.valid, 0);
      n = 0;
      while (wb.valid !== 1'b1 && n < 40) begin
        @(negedge clock);
        n++;
      end
      check(wb.valid, 1);
      check(32'(n), 32'(s * 4 + 3));
      check(32'(wb.reg_num), 32'h5);
      check(wb.value, rv.field_n + (32'h1 << s));
    end
  endtask

  task automatic t_predec();
    int t0;
    lag = 4'h8;
    send(16'h2501);
    t0 = cycles;
    rv.field_n = 32'h0000_0001;
    // offered while the pointer update is still pending
    send(16'h3500);
    check(32'(cycles - t0 > 8), 1);
    for (int s = 0; s < 3; s++) begin
      send({4'h3, 4'h6, 6'h00, 2'(s)});
      check(result.address, 32'h1 - (32'h1 << s));
      check(wb.valid, 1);
      check(32'(wb.reg_num), 32'h6);
      check(wb.value, 32'h1 - (32'h1 << s));
    end
    rv.field_n = 32'hffff_fffe;
  endtask

  task automatic t_illegal();
    for (int o = 12; o < 16; o++) begin
      send({4'(o), 12'h000});
      check(result.illegal, 1);
      check(32'(result.mode), 32'(eag_pkg::MODE_NONE));
    end
    send(16'h3503);
    check(result.illegal, 1);
    check(result.mem_access, 0);
    check(wb.valid, 0);
    send(16'h4300);
    check(result.illegal, 1);
    check(result.mem_access, 0);
    send(16'h2503);
    check(result.illegal, 1);
    check(req_ready, 1);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n   = 1'b0;
    req_valid = 1'b0;
    instr     = 16'h0000;
    regs      = '0;
    lag       = 4'h0;
    rv.field_n     = 32'hffff_fffe;
    rv.field_m     = 32'h0000_1000;
    rv.index_zero  = 32'h0000_0010;
    rv.global_base = 32'hffff_ff00;
    rv.pc          = 32'h0000_0004;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    t_addr();
    t_imm();
    t_postinc();
    t_predec();
    t_illegal();
    wrap_up();
  end
endmodule
